// ---- rtl/ptc_timer.sv ----
// The AHB-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module ptc_timer (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic timer_input_pin,
  input wire logic stop_mode_req,
  output logic timer_match_irq
);
  typedef struct packed {
    logic [9:0] ctrl;
    logic [15:0] cnt;
    logic [15:0] cmp;
    logic [15:0] cap;
    logic [15:0] cmp_pend;
    logic cmp_pv;
    logic [15:0] cap_pend;
    logic cap_pv;
    ptc_pkg::ptc_run_type run;
    logic filt_prev;
    logic [12:0] presc;
    logic dp_act;
    logic dp_wr;
    logic [7:0] dp_addr;
    logic [3:0] dp_lanes;
    logic [31:0] rdata;
    logic ready;
    logic irq;
  } ptc_state_type;

  ptc_state_type s_q;
  ptc_state_type s_d;
  logic filt;

  ptc_input_filter #(
    .STABLE(ptc_pkg::FILT_STABLE_CYC)
  ) u_filter (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .pin_in(timer_input_pin),
    .level(filt)
  );

  function automatic logic [3:0] lane_en(input logic [2:0] size, input logic [1:0] a);
    logic [3:0] m;
    m = 4'h0;
    case (size)
      3'h0: m = 4'h1 << a;
      3'h1: m = a[1] ? 4'hc : 4'h3;
      default: m = 4'hf;
    endcase
    return m;
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] ln);
    logic [15:0] r;
    r = old;
    if (ln[0]) begin
      r[7:0] = wd[7:0];
    end
    if (ln[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  function automatic logic [12:0] src_mask(input logic [1:0] sel, input logic div);
    logic [12:0] m;
    m = 13'h0000;
    case (sel)
      ptc_pkg::CLK_SLOW: m = 13'((14'h0001 << (ptc_pkg::EXP_SLOW + int'(div))) - 14'h0001);
      ptc_pkg::CLK_MID: m = 13'((14'h0001 << (ptc_pkg::EXP_MID + int'(div))) - 14'h0001);
      ptc_pkg::CLK_FAST: m = 13'((14'h0001 << (ptc_pkg::EXP_FAST + int'(div))) - 14'h0001);
      default: m = 13'h0000;
    endcase
    return m;
  endfunction

  logic [1:0] start_f;
  logic [1:0] mode_f;
  logic [1:0] clk_sel;
  logic tstop;
  logic cedge_single;
  logic acap;
  logic ext_clk;
  logic int_tick;
  logic trig;
  logic opp;
  logic cnt_tick;
  logic match;
  logic rise;
  logic fall;
  logic addr_ok;
  logic [15:0] cnt_inc;

  always_comb begin
    start_f = s_q.ctrl[ptc_pkg::START_LSB +: 2];
    mode_f = s_q.ctrl[ptc_pkg::MODE_LSB +: 2];
    clk_sel = s_q.ctrl[ptc_pkg::CLKSEL_LSB +: 2];
    tstop = s_q.ctrl[ptc_pkg::TSTOP_BIT];
    cedge_single = s_q.ctrl[ptc_pkg::CEDGE_BIT];
    acap = s_q.ctrl[ptc_pkg::ACAP_BIT];
    ext_clk = (clk_sel == ptc_pkg::CLK_EXT);
    int_tick = !ext_clk && ((s_q.presc & src_mask(clk_sel, s_q.ctrl[ptc_pkg::DIV_BIT]))
      == src_mask(clk_sel, s_q.ctrl[ptc_pkg::DIV_BIT]));
    rise = filt && !s_q.filt_prev;
    fall = !filt && s_q.filt_prev;
    trig = start_f[0] ? fall : rise;
    opp = start_f[0] ? rise : fall;
    cnt_tick = ext_clk ? trig : int_tick;
    match = (s_q.cnt == s_q.cmp);
    cnt_inc = s_q.cnt + 16'h0001;
    addr_ok = hsel && hready && htrans[1];
  end

  always_comb begin
    s_d = s_q;
    s_d.irq = 1'b0;
    s_d.ready = 1'b1;
    s_d.presc = s_q.presc + 13'h0001;
    s_d.filt_prev = filt;
    // Bus address phase
    s_d.dp_act = addr_ok;
    s_d.dp_wr = hwrite;
    s_d.dp_addr = haddr[7:0];
    s_d.dp_lanes = lane_en(hsize, haddr[1:0]);
    if (addr_ok && !hwrite) begin
      case ({haddr[7:2], 2'b00})
        ptc_pkg::ADDR_CTRL: s_d.rdata = {22'h000000, s_q.ctrl};
        ptc_pkg::ADDR_CMP: s_d.rdata = {16'h0000, s_q.cmp};
        ptc_pkg::ADDR_CAP: s_d.rdata = {16'h0000, s_q.cap};
        ptc_pkg::ADDR_STAT: s_d.rdata = {28'h0000000, s_q.cap_pv, s_q.cmp_pv, filt, s_q.run == ptc_pkg::PTC_RUN};
        ptc_pkg::ADDR_CNT: s_d.rdata = {16'h0000, s_q.cnt};
        default: s_d.rdata = 32'h00000000;
      endcase
    end
    // Bus data phase writes
    if (s_q.dp_act && s_q.dp_wr) begin
      case ({s_q.dp_addr[7:2], 2'b00})
        ptc_pkg::ADDR_CTRL: begin
          s_d.ctrl = 10'(merge16({6'h00, s_q.ctrl}, hwdata, s_q.dp_lanes));
        end
        ptc_pkg::ADDR_CMP: begin
          s_d.cmp_pend = merge16(s_q.cmp_pend, hwdata, s_q.dp_lanes);
          if (s_q.dp_lanes[1]) begin
            s_d.cmp_pv = 1'b1;
          end
        end
        ptc_pkg::ADDR_CAP: begin
          s_d.cap_pend = merge16(s_q.cap_pend, hwdata, s_q.dp_lanes);
          if (s_q.dp_lanes[1]) begin
            s_d.cap_pv = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    if (stop_mode_req) begin
      s_d.ctrl[ptc_pkg::START_LSB +: 2] = ptc_pkg::START_STOP;
    end
    // Pending values commit on a source tick
    if (cnt_tick && s_q.cmp_pv) begin
      s_d.cmp = s_q.cmp_pend;
      s_d.cmp_pv = 1'b0;
    end
    if (cnt_tick && s_q.cap_pv) begin
      s_d.cap = s_q.cap_pend;
      s_d.cap_pv = 1'b0;
    end
    // Counting
    if (start_f == ptc_pkg::START_STOP) begin
      s_d.cnt = 16'h0000;
      s_d.run = ptc_pkg::PTC_HALT;
    end else begin
      case (mode_f)
        ptc_pkg::MODE_TRIG: begin
          if (ext_clk) begin
            if (trig) begin
              s_d.cnt = cnt_inc;
            end else if (opp && match) begin
              s_d.cnt = 16'h0000;
              s_d.irq = 1'b1;
            end
          end else if (start_f == ptc_pkg::START_CMD) begin
            if (int_tick) begin
              s_d.cnt = match ? 16'h0000 : cnt_inc;
              s_d.irq = match;
            end
          end else if (s_q.run == ptc_pkg::PTC_HALT) begin
            if (trig) begin
              s_d.run = ptc_pkg::PTC_RUN;
              s_d.cnt = 16'h0000;
            end
          end else if (int_tick && match) begin
            s_d.cnt = 16'h0000;
            s_d.run = ptc_pkg::PTC_HALT;
            s_d.irq = 1'b1;
          end else if (opp && tstop) begin
            s_d.cnt = 16'h0000;
            s_d.run = ptc_pkg::PTC_HALT;
          end else if (int_tick) begin
            s_d.cnt = cnt_inc;
          end
        end
        ptc_pkg::MODE_WINDOW: begin
          if (int_tick && (filt ^ start_f[0])) begin
            s_d.cnt = match ? 16'h0000 : cnt_inc;
            s_d.irq = match;
          end
        end
        ptc_pkg::MODE_PULSE: begin
          if (s_q.run == ptc_pkg::PTC_HALT) begin
            if (trig) begin
              s_d.run = ptc_pkg::PTC_RUN;
            end
          end else if (opp) begin
            s_d.cap = s_q.cnt;
            s_d.irq = 1'b1;
            if (cedge_single) begin
              s_d.cnt = 16'h0001;
              s_d.run = ptc_pkg::PTC_HALT;
            end
          end else if (trig && !cedge_single) begin
            s_d.cap = s_q.cnt;
            s_d.irq = 1'b1;
            s_d.cnt = 16'h0000;
          end else if (int_tick) begin
            s_d.cnt = cnt_inc;
          end
        end
        default: begin
        end
      endcase
      if (acap && mode_f != ptc_pkg::MODE_PULSE && cnt_tick) begin
        s_d.cap = s_q.cnt;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
      s_q.ctrl <= ptc_pkg::CTRL_RESET;
      s_q.cmp <= ptc_pkg::CMP_RESET;
      s_q.cap <= ptc_pkg::CAP_RESET;
      s_q.run <= ptc_pkg::PTC_HALT;
      s_q.ready <= 1'b1;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign hreadyout = s_q.ready;
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;
  assign timer_match_irq = s_q.irq;

  default clocking @(posedge clk); endclocking
  default disable iff (srst || !ce);

  logic ext_trig_mode;
  assign ext_trig_mode = (mode_f == ptc_pkg::MODE_TRIG) && !ext_clk && start_f[1];

  sequence s_ext_running;
    ext_trig_mode && s_q.run == ptc_pkg::PTC_RUN;
  endsequence

  sequence s_early_opp;
    s_ext_running ##0 opp && !(int_tick && match);
  endsequence

  a_trig_start_run: assert property (ext_trig_mode && s_q.run == ptc_pkg::PTC_HALT && trig
    |=> s_q.run == ptc_pkg::PTC_RUN && s_q.cnt == 16'h0000)
    else $error("trigger edge did not start counter");
  a_match_halt_irq: assert property (s_ext_running ##0 int_tick && match
    |=> s_q.run == ptc_pkg::PTC_HALT && s_q.cnt == 16'h0000 && timer_match_irq)
    else $error("match did not clear halt and interrupt");
  a_early_opp_halt: assert property (s_early_opp ##0 tstop
    |=> s_q.run == ptc_pkg::PTC_HALT && s_q.cnt == 16'h0000 && !timer_match_irq)
    else $error("opposite edge did not halt quietly");
  a_no_stop_ignore: assert property (s_early_opp ##0 !tstop && !int_tick
    |=> s_q.run == ptc_pkg::PTC_RUN && $stable(s_q.cnt))
    else $error("opposite edge acted without trigger-stop");
  a_event_increment: assert property (mode_f == ptc_pkg::MODE_TRIG && ext_clk && start_f != ptc_pkg::START_STOP
    && trig && !stop_mode_req |=> s_q.cnt == $past(s_q.cnt) + 16'h0001)
    else $error("event edge did not increment");
  a_event_match_irq: assert property (mode_f == ptc_pkg::MODE_TRIG && ext_clk && start_f != ptc_pkg::START_STOP
    && opp && match |=> timer_match_irq && s_q.cnt == 16'h0000)
    else $error("event match missed at opposite edge");
  a_single_capture: assert property (mode_f == ptc_pkg::MODE_PULSE && start_f != ptc_pkg::START_STOP
    && s_q.run == ptc_pkg::PTC_RUN && opp && cedge_single
    |=> s_q.cap == $past(s_q.cnt) && s_q.cnt == 16'h0001 && timer_match_irq ##1 !timer_match_irq)
    else $error("single-edge capture wrong");
  a_double_clear: assert property (mode_f == ptc_pkg::MODE_PULSE && start_f != ptc_pkg::START_STOP
    && s_q.run == ptc_pkg::PTC_RUN && !opp && trig && !cedge_single
    |=> s_q.cap == $past(s_q.cnt) && s_q.cnt == 16'h0000 && timer_match_irq)
    else $error("double-edge trigger capture wrong");
  a_cmp_commit: assert property (cnt_tick && s_q.cmp_pv |=> s_q.cmp == $past(s_q.cmp_pend) && !s_q.cmp_pv)
    else $error("compare value not committed on tick");
  a_low_byte_hold: assert property (s_q.dp_act && s_q.dp_wr && s_q.dp_addr[7:2] == ptc_pkg::ADDR_CMP[7:2]
    && !s_q.dp_lanes[1] && !s_q.cmp_pv |=> !s_q.cmp_pv ##1 $stable(s_q.cmp))
    else $error("low byte write changed compare");
  a_stop_mode_clr: assert property (stop_mode_req |=> start_f == ptc_pkg::START_STOP
    ##1 s_q.cnt == 16'h0000 && s_q.run == ptc_pkg::PTC_HALT)
    else $error("stop request did not stop timer");
  a_auto_capture: assert property (acap && mode_f != ptc_pkg::MODE_PULSE && start_f != ptc_pkg::START_STOP
    && cnt_tick |=> s_q.cap == $past(s_q.cnt))
    else $error("auto-capture missed source tick");
  a_window_gate: assert property (mode_f == ptc_pkg::MODE_WINDOW && start_f != ptc_pkg::START_STOP
    && int_tick && !(filt ^ start_f[0]) |=> $stable(s_q.cnt) && !timer_match_irq)
    else $error("window counted outside gate");
endmodule

// ---- rtl/ptc_pkg.sv ----
// How it works
// - Trigger edge starts internal clock counting
// - Trigger-stop: match clears, halts, interrupts
// - Trigger-stop: early opposite edge halts silently
// - Halted counter restarts on next trigger
// - No trigger-stop: ignore opposite, retrigger edges
// - Filter drops short pulses, keeps long ones
// - Event mode counts selected pin edges
// - Event match checked at opposite edge
// - Auto-capture copies counter each source tick, except in pulse mode
// - Window mode counts while pin gate active
// - Single-edge: capture, interrupt, wait for trigger
// - Double-edge: capture both edges, clear at trigger
// - Single-edge counter rests at one
// - Compare commits after upper byte, source tick
// - Stop mode forces start field to zero
package ptc_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMP = 8'h04;
  localparam logic [7:0] ADDR_CAP = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;
  localparam logic [7:0] ADDR_CNT = 8'h10;
  localparam int CTRL_W = 10;
  localparam int START_LSB = 0;
  localparam int MODE_LSB = 2;
  localparam int CLKSEL_LSB = 4;
  localparam int TSTOP_BIT = 6;
  localparam int CEDGE_BIT = 7;
  localparam int ACAP_BIT = 8;
  localparam int DIV_BIT = 9;
  localparam logic [9:0] CTRL_RESET = 10'h000;
  localparam logic [15:0] CMP_RESET = 16'hffff;
  localparam logic [15:0] CAP_RESET = 16'h0000;
  localparam logic [1:0] START_STOP = 2'h0;
  localparam logic [1:0] START_CMD = 2'h1;
  localparam logic [1:0] MODE_TRIG = 2'h0;
  localparam logic [1:0] MODE_WINDOW = 2'h1;
  localparam logic [1:0] MODE_PULSE = 2'h2;
  localparam logic [1:0] CLK_SLOW = 2'h0;
  localparam logic [1:0] CLK_MID = 2'h1;
  localparam logic [1:0] CLK_FAST = 2'h2;
  localparam logic [1:0] CLK_EXT = 2'h3;
  localparam int EXP_SLOW = 11;
  localparam int EXP_MID = 7;
  localparam int EXP_FAST = 3;
  localparam int PRESC_W = 13;
  localparam int FILT_REJECT_CYC = 4;
  localparam int FILT_DETECT_CYC = 12;
  localparam int FILT_STABLE_CYC = (FILT_REJECT_CYC + FILT_DETECT_CYC) / 2;
  typedef enum logic [1:0] {
    PTC_HALT = 2'b01,
    PTC_RUN = 2'b10
  } ptc_run_type;
endpackage

// ---- rtl/ptc_input_filter.sv ----
`timescale 1ns/1ps
module ptc_input_filter #(
  parameter int STABLE = ptc_pkg::FILT_STABLE_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic pin_in,
  output logic level
);
  typedef struct packed {
    logic lvl;
    logic [4:0] cnt;
  } ptc_filt_type;

  ptc_filt_type s_q;
  ptc_filt_type s_d;

  // Level follows pin only after STABLE equal samples
  always_comb begin
    s_d = s_q;
    if (pin_in == s_q.lvl) begin
      s_d.cnt = 5'h00;
    end else if (s_q.cnt == 5'(STABLE - 1)) begin
      s_d.lvl = pin_in;
      s_d.cnt = 5'h00;
    end else begin
      s_d.cnt = s_q.cnt + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign level = s_q.lvl;

  default clocking @(posedge clk); endclocking
  default disable iff (srst || !ce);

  a_filt_change_count: assert property ($changed(s_q.lvl) |-> $past(s_q.cnt) == 5'(STABLE - 1))
    else $error("filter changed before stable count");
  a_filt_no_short: assert property ((pin_in != s_q.lvl) ##1 (pin_in == s_q.lvl) |=> $stable(s_q.lvl))
    else $error("one-cycle glitch passed filter");
endmodule

// ---- verif/ptc_pin_src.sv ----
`timescale 1ns/1ps
module ptc_pin_src (
  input wire logic clk,
  output logic pin
);
  int min_phase = 8;
  initial begin
    pin = 1'b0;
  end
  // Drives a level right after an edge, holds it n cycles
  task automatic hold(input logic v, input int n);
    pin <= v;
    repeat (n) @(posedge clk);
  endtask
  // Pulse train, phases never below the minimum
  task automatic train(input int hi, input int lo, input int n);
    repeat (n) begin
      hold(1'b1, (hi < min_phase) ? min_phase : hi);
      hold(1'b0, (lo < min_phase) ? min_phase : lo);
    end
  endtask
endmodule

// ---- verif/ptc_timer_test.sv ----
`timescale 1ns/1ps
module ptc_timer_test;
  logic clk, srst, hsel, hwrite, hreadyout, hresp, pin, stop_req, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] v;
  logic [15:0] c [4];
  logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14};
  logic [31:0] rv [5] = '{{22'h0, ptc_pkg::CTRL_RESET}, {16'h0, ptc_pkg::CMP_RESET}, 32'h0, 32'h0, 32'h0};
  int errors = 0;
  int checked = 0;
  int irq_cnt = 0;
  int tcnt = 0;
  int el, n, w;
  ptc_timer dut (.clk(clk), .srst(srst), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .timer_input_pin(pin), .stop_mode_req(stop_req), .timer_match_irq(irq));
  ptc_pin_src src (.clk(clk), .pin(pin));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    tcnt <= tcnt + 1;
    if (irq === 1'b1) begin
      irq_cnt <= irq_cnt + 1;
    end
    if (tcnt == 40000) begin
      errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One AHB-Lite single transfer, waits on hready in both phases
  task automatic ahb(input logic wr_en, input logic [7:0] a, input logic [31:0] d, input logic [2:0] sz);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr_en;
    hsize <= sz;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, 3'h2);
  endtask
  task automatic rdr(input logic [7:0] a);
    ahb(1'b0, a, 32'h0, 3'h2);
  endtask
  task automatic wait_irq(input int target, input int lim);
    el = 0;
    while (irq_cnt < target && el < lim) begin
      @(posedge clk);
      el++;
    end
    if (irq_cnt < target) begin
      chk("irq wait", 1'b0, 1'b1);
    end
  endtask
  // Stop, load compare, wait for commit, set mode, then start
  task automatic setup(input logic [15:0] cmp, input logic [9:0] ctl);
    int k;
    k = 0;
    wr(ptc_pkg::ADDR_CTRL, 32'h20);
    wr(ptc_pkg::ADDR_CMP, {16'h0, cmp});
    do begin
      rdr(ptc_pkg::ADDR_STAT);
      k++;
    end while (rd[2] !== 1'b0 && k < 50);
    rdr(ptc_pkg::ADDR_CMP);
    chk("compare", rd, {16'h0, cmp});
    wr(ptc_pkg::ADDR_CTRL, {22'h0, ctl & 10'h3fc});
    wr(ptc_pkg::ADDR_CTRL, {22'h0, ctl});
  endtask
  initial begin
    srst = 1'b1;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    stop_req = 1'b0;
    void'($urandom(90));
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    foreach (ra[i]) begin
      rdr(ra[i]);
      chk("reset value", rd, rv[i]);
    end
    chk("hresp", hresp, 1'b0);
    wr(ptc_pkg::ADDR_CTRL, 32'h20);
    ahb(1'b1, ptc_pkg::ADDR_CMP, 32'h12, 3'h0);
    repeat (40) @(posedge clk);
    rdr(ptc_pkg::ADDR_CMP);
    chk("low byte only", rd, {16'h0, ptc_pkg::CMP_RESET});
    $display("done regs");
    setup(16'h5, 10'h062);
    src.hold(1'b1, 1);
    wait_irq(1, 200);
    chk("match delay", el >= 45 && el <= 66, 1'b1);
    rdr(ptc_pkg::ADDR_CNT);
    chk("cleared", rd, 32'h0);
    rdr(ptc_pkg::ADDR_STAT);
    chk("halted", rd[0], 1'b0);
    setup(16'd100, 10'h062);
    src.hold(1'b0, 40);
    src.hold(1'b1, 12 + $urandom_range(20));
    src.hold(1'b0, 300);
    rdr(ptc_pkg::ADDR_CNT);
    chk("early stop", rd, 32'h0);
    chk("no irq", irq_cnt, 1);
    src.hold(1'b1, 4);
    src.hold(1'b0, 100);
    rdr(ptc_pkg::ADDR_STAT);
    chk("glitch", rd[0], 1'b0);
    src.hold(1'b1, 100);
    rdr(ptc_pkg::ADDR_CNT);
    chk("restart", rd >= 9 && rd <= 12, 1'b1);
    setup(16'd30, 10'h022);
    src.hold(1'b0, 40);
    src.hold(1'b1, 40);
    src.hold(1'b0, 40);
    src.hold(1'b1, 40);
    wait_irq(2, 400);
    chk("ignore edges", 120 + el >= 245 && 120 + el <= 270, 1'b1);
    chk("irq count", irq_cnt, 2);
    $display("done trigger");
    src.hold(1'b0, 20);
    setup(16'hffff, 10'h126);
    src.hold(1'b0, 100);
    rdr(ptc_pkg::ADDR_CNT);
    chk("gate closed", rd, 32'h0);
    src.hold(1'b1, 80);
    src.hold(1'b0, 40);
    rdr(ptc_pkg::ADDR_CNT);
    v = rd[15:0];
    chk("gate open", v >= 9 && v <= 11, 1'b1);
    rdr(ptc_pkg::ADDR_CAP);
    chk("auto capture", rd, {16'h0, v});
    stop_req <= 1'b1;
    @(posedge clk);
    stop_req <= 1'b0;
    rdr(ptc_pkg::ADDR_CTRL);
    chk("stop mode", rd, 32'h124);
    $display("done window");
    setup(16'd6, 10'h032);
    n = 2 + $urandom_range(2);
    w = 12 + $urandom_range(8);
    src.train(w, w, n);
    rdr(ptc_pkg::ADDR_CNT);
    chk("events", rd, n);
    src.train(w, w, 5 - n);
    src.hold(1'b1, 40);
    chk("irq before fall", irq_cnt, 2);
    src.hold(1'b0, 40);
    chk("irq after fall", irq_cnt, 3);
    rdr(ptc_pkg::ADDR_CNT);
    chk("event clear", rd, 32'h0);
    $display("done event");
    setup(16'hffff, 10'h0aa);
    fork
      src.train(160, 160, 3);
      for (int i = 0; i < 3; i++) begin
        wait_irq(4 + i, 400);
        rdr(ptc_pkg::ADDR_CAP);
        c[i] = rd[15:0];
      end
    join
    chk("rest at one", c[1], c[0] + 16'h1);
    chk("repeat", c[2], c[1]);
    chk("width", c[1] >= 20 && c[1] <= 21, 1'b1);
    setup(16'hffff, 10'h02a);
    fork
      src.train(160, 240, 3);
      for (int i = 0; i < 4; i++) begin
        wait_irq(7 + i, 500);
        rdr(ptc_pkg::ADDR_CAP);
        c[i] = rd[15:0];
      end
    join
    chk("high part", c[2] >= 19 && c[2] <= 21, 1'b1);
    chk("period", c[3] >= 49 && c[3] <= 51, 1'b1);
    chk("irq total", irq_cnt, 11);
    $display("done pulse");
    finish_test();
  end
endmodule
